// ### shared/comparator_pkg.sv
// Constants, field positions and types of the comparator control block.
// Assumes a 16-bit control register reached over a plain strobe port.
package comparator_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;

  localparam int unsigned ON_BIT        = 15;
  localparam int unsigned UNUSED_BIT    = 14;
  localparam int unsigned IDLE_STOP_BIT = 13;
  localparam int unsigned HYST_HI       = 12;
  localparam int unsigned HYST_LO       = 11;
  localparam int unsigned FILT_EN_BIT   = 10;
  localparam int unsigned FCLK_BIT      = 9;
  localparam int unsigned REF_OE_BIT    = 8;
  localparam int unsigned INPUT_SELECT_HI      = 7;
  localparam int unsigned INPUT_SELECT_LO      = 6;
  localparam int unsigned EXT_REF_BIT   = 5;
  localparam int unsigned HYST_POL_BIT  = 4;
  localparam int unsigned STATUS_BIT    = 3;
  localparam int unsigned ALT_BIT       = 2;
  localparam int unsigned OUT_POL_BIT   = 1;
  localparam int unsigned RANGE_BIT     = 0;

  localparam logic [DATA_W-1:0] CTRL_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 16'hBFF7;

  localparam logic [1:0] HYST_NONE = 2'h0;
  localparam logic [1:0] HYST_5    = 2'h1;
  localparam logic [1:0] HYST_10   = 2'h2;
  localparam logic [1:0] HYST_20   = 2'h3;
  localparam logic [4:0] MV_0      = 5'h00;
  localparam logic [4:0] MV_5      = 5'h05;
  localparam logic [4:0] MV_10     = 5'h0A;
  localparam logic [4:0] MV_20     = 5'h14;

  localparam int unsigned MUX_W    = 5;
  localparam logic [MUX_W-1:0] MUX_NONE = 5'h00;
  localparam logic [MUX_W-1:0] MUX_PGA  = 5'h10;
  localparam logic [MUX_W-1:0] MUX_ONE  = 5'h01;

  localparam int unsigned FILTER_SAMPLES = 3;
  localparam int unsigned STRETCH_TICKS  = 3;

  typedef enum logic [1:0] {PWR_OFF, PWR_RUN, PWR_HALT} power_t;

endpackage

// ### shared/filter_if.sv
// Carrier between the control logic and the output filter.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface filter_if;
  logic tick;
  logic filterOn;
  logic sample;
  logic clear;
  logic result;
  modport ctrl (output tick, output filterOn, output sample,
                output clear, input result);
  modport filt (input tick, input filterOn, input sample,
                input clear, output result);
endinterface
`default_nettype wire

// ### logic/comp_filter.sv
// Digital output filter and pulse stretcher for the comparator output.
// Assumes tick, sample and clear come from logic on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module comp_filter #(
  parameter int unsigned SAMPLES = comparator_pkg::FILTER_SAMPLES,
  parameter int unsigned STRETCH = comparator_pkg::STRETCH_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  filter_if.filt   fp
);
  import comparator_pkg::*;

  localparam int unsigned CW = $clog2(SAMPLES + 1);
  localparam int unsigned SW = $clog2(STRETCH + 1);

  logic [CW-1:0] agree_r;
  logic [CW-1:0] agree_nxt;
  logic          filtered_r;
  logic          filtered_nxt;
  logic [SW-1:0] stretch_r;
  logic [SW-1:0] stretch_nxt;
  logic          result_r;
  logic          result_nxt;
  logic          stage;

  always_comb begin
    agree_nxt    = agree_r;
    filtered_nxt = filtered_r;
    stretch_nxt  = stretch_r;
    result_nxt   = result_r;
    stage        = 1'b0;
    if (fp.clear) begin
      agree_nxt    = '0;
      filtered_nxt = 1'b0;
      stretch_nxt  = '0;
      result_nxt   = 1'b0;
    end else if (fp.tick) begin
      // A change passes only after SAMPLES agreeing ticks
      if (!fp.filterOn || fp.sample == filtered_r) begin
        agree_nxt = '0;
      end else if (agree_r == CW'(SAMPLES - 1)) begin
        agree_nxt    = '0;
        filtered_nxt = fp.sample;
      end else begin
        agree_nxt = agree_r + CW'(1);
      end
      if (!fp.filterOn) begin
        filtered_nxt = fp.sample;
      end
      stage = fp.filterOn ? filtered_nxt : fp.sample;
      if (stage) begin
        stretch_nxt = SW'(STRETCH);
      end else if (stretch_r != '0) begin
        stretch_nxt = stretch_r - SW'(1);
      end
      result_nxt = stage | (stretch_r != '0);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      agree_r    <= '0;
      filtered_r <= 1'b0;
      stretch_r  <= '0;
      result_r   <= 1'b0;
    end else begin
      agree_r    <= agree_nxt;
      filtered_r <= filtered_nxt;
      stretch_r  <= stretch_nxt;
      result_r   <= result_nxt;
    end
  end

  assign fp.result = result_r;

  clearOut_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fp.clear |=> !result_r)
    else $error("filter output not cleared");

endmodule // comp_filter
`default_nettype wire

// ### logic/analog_comparator_control.sv
// Control register, power state, input routing and output status of one
// analog comparator channel. Assumes the analog macro, the reference DAC
// and the device idle logic sit outside; comparator and PWM clock pins are
// asynchronous, idle signals come from logic on clk_sys.
// Functional notes
// - Top bit powers comparator on, off saves power
// - Idle-stop bit halts comparator in idle
// - Any instance idle-stop halts all in idle
// - Hysteresis code: none, 5, 10, 20 mV
// - Filter enable passes output through filter
// - Clock select set: filter uses PWM clock
// - Clock select clear: filter uses system clock
// - Reference output enable connects DAC to pin
// - Normal inputs: codes pick pins A-D
// - Alternate inputs: low codes pick second amplifier
// - Status bit is hardware only, resets zero
// - Bit 14 reads zero; all reset zero
`timescale 1ns/100ps
`default_nettype none
module analog_comparator_control (
  input  wire logic                                clk_sys,
  input  wire logic                                rst_n,
  input  wire logic [comparator_pkg::ADDR_W-1:0]   addr,
  input  wire logic [comparator_pkg::DATA_W-1:0]   wrData,
  input  wire logic                                wrStrobe,
  input  wire logic                                rdStrobe,
  output var  logic [comparator_pkg::DATA_W-1:0]   rdData,
  input  wire logic                                compRaw,
  input  wire logic                                pwmClk,
  input  wire logic                                idleMode,
  input  wire logic                                idleStopOthers,
  output var  logic                                idleStopOut,
  output var  logic                                comparatorPowered,
  output var  logic [1:0]                          hysteresisSelect,
  output var  logic [4:0]                          hysteresisMv,
  output var  logic                                referenceOutputEnable,
  output var  logic [comparator_pkg::MUX_W-1:0]    inputSelectOneHot,
  output var  logic                                externalReference,
  output var  logic                                hysteresisPolarity,
  output var  logic                                outputPolarity,
  output var  logic                                rangeSelect,
  output var  logic                                comparatorStatus
);
  import comparator_pkg::*;

  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] ctrl_nxt;
  logic [DATA_W-1:0] rdData_r;
  logic [DATA_W-1:0] rdData_nxt;
  logic [DATA_W-1:0] readVal;
  logic              ctrlHit;
  logic [4:0]        hystMv_r;
  logic [4:0]        hystMv_nxt;
  logic [MUX_W-1:0]  mux_r;
  logic [MUX_W-1:0]  mux_nxt;
  logic [1:0]        hystCode;
  logic [1:0]        inselCode;

  power_t            state_r;
  power_t            state_nxt;
  logic              powered_r;
  logic              powered_nxt;
  logic              idleHalt;
  logic              status_r;
  logic              status_nxt;

  logic              cmpMeta_r;
  logic              cmpSync_r;
  logic              pwmMeta_r;
  logic              pwmSync_r;
  logic              pwmPrev_r;
  logic              pwmRise;

  filter_if fbus ();

  comp_filter #(
    .SAMPLES (FILTER_SAMPLES),
    .STRETCH (STRETCH_TICKS)
  ) u_filter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .fp      (fbus.filt)
  );

  // Register port
  always_comb begin
    ctrlHit = (addr == CTRL_ADDR);
    readVal = ctrl_r;
    readVal[STATUS_BIT] = status_r;
    readVal[UNUSED_BIT] = 1'b0;
    ctrl_nxt = ctrl_r;
    if (wrStrobe && ctrlHit) begin
      // Status and the unused bit are never stored
      ctrl_nxt = wrData & CTRL_WR_MASK;
    end
    rdData_nxt = '0;
    if (rdStrobe && ctrlHit) begin
      rdData_nxt = readVal;
    end else if (rdStrobe) begin
      rdData_nxt = '0;
    end
  end

  // Decoded views of the control fields
  always_comb begin
    hystCode  = ctrl_nxt[HYST_HI:HYST_LO];
    inselCode = ctrl_nxt[INPUT_SELECT_HI:INPUT_SELECT_LO];
    case (hystCode)
      HYST_20: hystMv_nxt = MV_20;
      HYST_10: hystMv_nxt = MV_10;
      HYST_5:  hystMv_nxt = MV_5;
      default: hystMv_nxt = MV_0;
    endcase
    if (!ctrl_nxt[ALT_BIT]) begin
      mux_nxt = MUX_ONE << inselCode;
    end else if (!inselCode[1]) begin
      mux_nxt = MUX_PGA;
    end else begin
      mux_nxt = MUX_NONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= CTRL_RESET;
      rdData_r <= '0;
      hystMv_r <= MV_0;
      // Code 00 with normal inputs is pin A, so the reset view is pin A
      mux_r    <= MUX_ONE;
    end else begin
      ctrl_r   <= ctrl_nxt;
      rdData_r <= rdData_nxt;
      hystMv_r <= hystMv_nxt;
      mux_r    <= mux_nxt;
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmpMeta_r <= 1'b0;
      cmpSync_r <= 1'b0;
      pwmMeta_r <= 1'b0;
      pwmSync_r <= 1'b0;
      pwmPrev_r <= 1'b0;
    end else begin
      cmpMeta_r <= compRaw;
      cmpSync_r <= cmpMeta_r;
      pwmMeta_r <= pwmClk;
      pwmSync_r <= pwmMeta_r;
      pwmPrev_r <= pwmSync_r;
    end
  end

  assign pwmRise = pwmSync_r & ~pwmPrev_r;

  // Power state: off, running, or halted by idle
  always_comb begin
    // Any idle-stop bit in the device halts every comparator in idle
    idleHalt = idleMode &&
               (ctrl_r[IDLE_STOP_BIT] || idleStopOthers);
    if (!ctrl_r[ON_BIT]) begin
      state_nxt = PWR_OFF;
    end else if (idleHalt) begin
      state_nxt = PWR_HALT;
    end else begin
      state_nxt = PWR_RUN;
    end
    powered_nxt = (state_nxt == PWR_RUN);
    case (state_r)
      PWR_OFF:  status_nxt = 1'b0;
      PWR_HALT: status_nxt = status_r;
      default:  status_nxt = fbus.result;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= PWR_OFF;
      powered_r <= 1'b0;
      status_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      powered_r <= powered_nxt;
      status_r  <= status_nxt;
    end
  end

  // Filter drive
  assign fbus.tick     = ctrl_r[FCLK_BIT] ? pwmRise : 1'b1;
  assign fbus.filterOn = ctrl_r[FILT_EN_BIT];
  assign fbus.sample   = cmpSync_r ^ ctrl_r[OUT_POL_BIT];
  assign fbus.clear    = (state_r != PWR_RUN);

  // Outputs
  assign rdData                = rdData_r;
  assign idleStopOut           = ctrl_r[IDLE_STOP_BIT];
  assign comparatorPowered     = powered_r;
  assign hysteresisSelect      = ctrl_r[HYST_HI:HYST_LO];
  assign hysteresisMv          = hystMv_r;
  assign referenceOutputEnable = ctrl_r[REF_OE_BIT];
  assign inputSelectOneHot     = mux_r;
  assign externalReference     = ctrl_r[EXT_REF_BIT];
  assign hysteresisPolarity    = ctrl_r[HYST_POL_BIT];
  assign outputPolarity        = ctrl_r[OUT_POL_BIT];
  assign rangeSelect           = ctrl_r[RANGE_BIT];
  assign comparatorStatus      = status_r;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic runBypass;
  assign runBypass = (state_r == PWR_RUN) && !ctrl_r[FILT_EN_BIT] &&
                     !ctrl_r[FCLK_BIT];

  power_off_a: assert property (
    !ctrl_r[ON_BIT] |=> !comparatorPowered ##1 !comparatorStatus)
    else $error("comparator still active while off");

  idle_stop_a: assert property (
    ctrl_r[ON_BIT] && idleMode && ctrl_r[IDLE_STOP_BIT]
    |=> !comparatorPowered ##1 $stable(comparatorStatus))
    else $error("comparator ran in idle with stop set");

  idle_run_a: assert property (
    ctrl_r[ON_BIT] && !ctrl_r[IDLE_STOP_BIT] && !idleStopOthers
    |=> comparatorPowered)
    else $error("comparator halted without any stop request");

  shared_idle_a: assert property (
    ctrl_r[ON_BIT] && idleMode && idleStopOthers |=> !comparatorPowered)
    else $error("other instance idle stop ignored");

  hyst_map_a: assert property (
    hysteresisMv == ((hysteresisSelect == HYST_20) ? MV_20 :
                     (hysteresisSelect == HYST_10) ? MV_10 :
                     (hysteresisSelect == HYST_5)  ? MV_5  : MV_0))
    else $error("hysteresis level does not match code");

  filter_bypass_a: assert property (
    $rose(fbus.sample) && runBypass ##1 runBypass |=> comparatorStatus)
    else $error("bypassed output late on system clock");

  pwm_gate_a: assert property (
    ctrl_r[FCLK_BIT] && !pwmRise && state_r == PWR_RUN
    |=> $stable(fbus.result))
    else $error("filter advanced without a PWM clock edge");

  ref_out_a: assert property (
    wrStrobe && ctrlHit
    |=> referenceOutputEnable == $past(wrData[REF_OE_BIT]))
    else $error("reference output enable not written");

  mux_pins_a: assert property (
    !ctrl_r[ALT_BIT]
    |-> inputSelectOneHot == (MUX_ONE << ctrl_r[INPUT_SELECT_HI:INPUT_SELECT_LO]))
    else $error("wrong comparator input pin selected");

  mux_alt_a: assert property (
    ctrl_r[ALT_BIT] |-> inputSelectOneHot ==
      (ctrl_r[INPUT_SELECT_HI] ? MUX_NONE : MUX_PGA))
    else $error("wrong alternate input selected");

  status_wr_a: assert property (
    wrStrobe && ctrlHit && state_r == PWR_OFF && wrData[STATUS_BIT]
    |=> !comparatorStatus)
    else $error("software write altered status");

  read_back_a: assert property (
    rdStrobe && ctrlHit |=> !rdData[UNUSED_BIT] &&
      rdData[ON_BIT] == $past(ctrl_r[ON_BIT]) &&
      rdData[STATUS_BIT] == $past(status_r))
    else $error("control read back wrong");

  store_bits_a: assert property (
    wrStrobe && ctrlHit |=>
      externalReference == $past(wrData[EXT_REF_BIT]) &&
      hysteresisPolarity == $past(wrData[HYST_POL_BIT]) &&
      outputPolarity == $past(wrData[OUT_POL_BIT]) &&
      rangeSelect == $past(wrData[RANGE_BIT]))
    else $error("storage bit not written");

  power_on_a: assert property (
    ctrl_r[ON_BIT] && !idleMode |=> comparatorPowered)
    else $error("comparator not running while on");

  status_hold_a: assert property (
    state_r == PWR_HALT |=> $stable(comparatorStatus))
    else $error("status changed during idle halt");

  ref_hold_a: assert property (
    !(wrStrobe && ctrlHit) |=> $stable(referenceOutputEnable))
    else $error("reference output enable changed without a write");

  read_idle_a: assert property (
    !(rdStrobe && ctrlHit) |=> rdData == '0)
    else $error("read data not zero outside a read");

  unused_zero_a: assert property (
    !ctrl_r[UNUSED_BIT] && !ctrl_r[STATUS_BIT])
    else $error("unwritable control bit stored");

endmodule // analog_comparator_control
`default_nettype wire

// ### dv/tb_analog_comparator_control.sv
// Self-checking bench for the comparator control block: register port,
// field decode, power and idle control, and the comparator status path.
// Assumes only the top module's ports and the comparator package.
`timescale 1ns/100ps
`default_nettype none
module tb_analog_comparator_control;
  import comparator_pkg::*;

  logic                clk_sys;
  logic                rst_n;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wrData;
  logic                wrStrobe;
  logic                rdStrobe;
  logic [DATA_W-1:0]   rdData;
  logic                compRaw;
  logic                pwmClk;
  logic                idleMode;
  logic                idleStopOthers;
  logic                idleStopOut;
  logic                comparatorPowered;
  logic [1:0]          hysteresisSelect;
  logic [4:0]          hysteresisMv;
  logic                referenceOutputEnable;
  logic [MUX_W-1:0]    inputSelectOneHot;
  logic                externalReference;
  logic                hysteresisPolarity;
  logic                outputPolarity;
  logic                rangeSelect;
  logic                comparatorStatus;
  int                  err_total;
  int                  total_checks;
  int                  ctrlModel;
  logic [31:0]         rngState;
  logic [15:0]         d;

  analog_comparator_control dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .compRaw(compRaw), .pwmClk(pwmClk), .idleMode(idleMode),
    .idleStopOthers(idleStopOthers), .idleStopOut(idleStopOut),
    .comparatorPowered(comparatorPowered),
    .hysteresisSelect(hysteresisSelect), .hysteresisMv(hysteresisMv),
    .referenceOutputEnable(referenceOutputEnable),
    .inputSelectOneHot(inputSelectOneHot),
    .externalReference(externalReference),
    .hysteresisPolarity(hysteresisPolarity),
    .outputPolarity(outputPolarity), .rangeSelect(rangeSelect),
    .comparatorStatus(comparatorStatus)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single write cycle; the model keeps only the writable bits
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr     <= a;
    wrData   <= v;
    wrStrobe <= 1'b1;
    @(posedge clk_sys);
    wrStrobe <= 1'b0;
    if (a == 4'h0)
      ctrlModel = int'(v & 16'hBFF7);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge clk_sys);
    rdStrobe <= 1'b0;
    #1 chk("rdData", e, rdData);
    @(posedge clk_sys);
    #1 chk("rdDataAfter", 16'h0000, rdData);
  endtask

  task automatic fields_chk;
    int          mv;
    logic [1:0]  s;
    logic [15:0] oh;
    logic [15:0] m;
    logic [3:0]  pb;
    m = 16'(ctrlModel);
    s = m[7:6];
    case (m[12:11])
      2'h0:    mv = 0;
      2'h1:    mv = 5;
      2'h2:    mv = 10;
      default: mv = 20;
    endcase
    if (m[2])
      oh = (s < 2) ? 16'h0010 : 16'h0000;
    else
      oh = 16'(1 << s);
    pb = {externalReference, hysteresisPolarity, outputPolarity,
          rangeSelect};
    chk("hysteresisSelect", 16'(m[12:11]), 16'(hysteresisSelect));
    chk("hysteresisMv", 16'(mv), 16'(hysteresisMv));
    chk("inputSelectOneHot", oh, 16'(inputSelectOneHot));
    chk("refOutEnable", 16'(m[8]), 16'(referenceOutputEnable));
    chk("idleStopOut", 16'(m[13]), 16'(idleStopOut));
    chk("plainBits", 16'({m[5], m[4], m[1], m[0]}), 16'(pb));
  endtask

  task automatic pwr_chk(input logic e);
    repeat (3) @(negedge clk_sys);
    chk("powered", 16'(e), 16'(comparatorPowered));
  endtask

  // Bounded wait for the status to reach a level; a hang ends the run
  task automatic wait_stat(input logic e, input int bound);
    int n;
    for (n = 0; n < bound && comparatorStatus !== e; n++)
      @(negedge clk_sys);
    chk("comparatorStatus", 16'(e), 16'(comparatorStatus));
    if (comparatorStatus !== e)
      tally_and_finish();
  endtask

  task automatic stay_stat(input logic e, input int k);
    repeat (k) begin
      @(negedge clk_sys);
      chk("statusHeld", 16'(e), 16'(comparatorStatus));
    end
  endtask

  task automatic glitch;
    @(posedge clk_sys);
    compRaw <= 1'b1;
    @(posedge clk_sys);
    compRaw <= 1'b0;
  endtask

  initial begin
    rst_n = 1'b0;
    addr = '0;
    wrData = '0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    compRaw = 1'b0;
    pwmClk = 1'b0;
    idleMode = 1'b0;
    idleStopOthers = 1'b0;
    err_total = 0;
    total_checks = 0;
    ctrlModel = 0;
    rngState = 32'h58BF1815;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    fields_chk();
    chk("statusReset", 16'h0000, 16'(comparatorStatus));
    rd_chk(4'h0, 16'h0000);
    // Every hysteresis, input and alternate code, other bits random, off
    for (int i = 0; i < 32; i++) begin
      rngState = xorshift(rngState);
      d = rngState[15:0];
      d[15] = 1'b0;
      d[12:11] = 2'(i);
      d[7:6] = 2'(i >> 2);
      d[2] = i[4];
      // Single instance: only it ever sets the reference output enable
      wr(4'h0, d);
      @(negedge clk_sys);
      fields_chk();
      rd_chk(4'h0, 16'(ctrlModel));
    end
    wr(4'h5, 16'hFFFF);
    rd_chk(4'h5, 16'h0000);
    rd_chk(4'h0, 16'(ctrlModel));
    // Power and idle behaviour
    wr(4'h0, 16'h8000);
    pwr_chk(1'b1);
    @(posedge clk_sys) idleMode <= 1'b1;
    pwr_chk(1'b1);
    wr(4'h0, 16'hA000);
    pwr_chk(1'b0);
    @(posedge clk_sys) idleMode <= 1'b0;
    pwr_chk(1'b1);
    wr(4'h0, 16'h8000);
    @(posedge clk_sys) idleStopOthers <= 1'b1;
    idleMode <= 1'b1;
    pwr_chk(1'b0);
    @(posedge clk_sys) idleMode <= 1'b0;
    idleStopOthers <= 1'b0;
    pwr_chk(1'b1);
    // Status path on the system clock, filter bypassed
    @(posedge clk_sys) compRaw <= 1'b1;
    wait_stat(1'b1, 10);
    @(posedge clk_sys) compRaw <= 1'b0;
    wait_stat(1'b0, 16);
    glitch();
    wait_stat(1'b1, 10);
    wait_stat(1'b0, 16);
    // Software cannot set the status bit
    wr(4'h0, 16'h8008);
    rd_chk(4'h0, 16'h8000);
    // Filter on: a one-cycle glitch is rejected, a steady level passes
    wr(4'h0, 16'h8400);
    glitch();
    stay_stat(1'b0, 12);
    @(posedge clk_sys) compRaw <= 1'b1;
    wait_stat(1'b1, 16);
    @(posedge clk_sys) compRaw <= 1'b0;
    wait_stat(1'b0, 24);
    // Output polarity inverts the path; status reads back
    wr(4'h0, 16'h8002);
    wait_stat(1'b1, 16);
    // A write with the status bit clear leaves the live status alone
    wr(4'h0, 16'h8002);
    rd_chk(4'h0, 16'h800A);
    wr(4'h0, 16'h0002);
    wait_stat(1'b0, 8);
    // PWM clock select: no ticks, no change; ticks let the level through
    wr(4'h0, 16'h8600);
    @(posedge clk_sys) compRaw <= 1'b1;
    stay_stat(1'b0, 12);
    repeat (16) begin
      repeat (3) @(posedge clk_sys);
      pwmClk <= ~pwmClk;
    end
    wait_stat(1'b1, 8);
    // Reset in mid-run returns every control bit and the status to zero, and input select to pin A
    @(posedge clk_sys) rst_n <= 1'b0;
    ctrlModel = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    fields_chk();
    chk("statusReset", 16'h0000, 16'(comparatorStatus));
    rd_chk(4'h0, 16'h0000);
    tally_and_finish();
  end

endmodule // tb_analog_comparator_control
`default_nettype wire
